// ==== rtl/vpa_pkg.sv ====
/*
 port arbitration table package: register offsets, fields, reset values,
 phase slot codes and the carrier structs of the register port and the grant.
 assumes a single clock and a plain strobe register port.
*/
package vpa_pkg;
    localparam logic [11:0] OFF_STATUS    = 12'h218;
    localparam logic [11:0] OFF_CONTROL   = 12'h21c;
    localparam logic [11:0] OFF_TBL_ZERO  = 12'h220;
    localparam logic [11:0] OFF_TBL_ONE   = 12'h224;

    localparam int          BIT_DIRTY     = 0;
    localparam int          BIT_PENDING   = 1;
    localparam int          BIT_LOAD      = 16;
    localparam int          SEL_LSB       = 17;
    localparam int          NUM_PHASES    = 16;
    localparam int          SLOT_W        = 4;
    localparam int          SLOTS_PER_WD  = 8;

    localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
    localparam logic [63:0] TABLE_RESET   = 64'h2176_5432_1765_4321;
    localparam logic [2:0]  SEL_RESET     = 3'h0;
    // arbitration schemes whose selector value consults the table
    localparam logic [7:0]  SEL_USES_TBL  = 8'h0e;

    localparam logic [3:0]  PORT_UP       = 4'h0;
    localparam logic [3:0]  PORT_FIRST_DN = 4'h2;
    localparam logic [3:0]  PORT_LAST_DN  = 4'h4;

    // cycles the arbiter needs to copy the table after a load request
    localparam logic [4:0]  LOAD_CYCLES   = 5'h10;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } vpa_req_s;

    typedef struct packed {
        logic        valid;
        logic [3:0]  port;
        logic [3:0]  phase;
    } vpa_grant_s;
endpackage : vpa_pkg

// ==== rtl/vpa_arb_table.sv ====
/*
 port arbitration table of the single virtual channel resource: table
 words, load control, status and a phase sequencer for the arbiter.
 assumes synchronous register strobes and a period pulse from the core.
*/
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - any software write of a table word sets the dirty bit 0
// - downstream ports always read the dirty bit as zero
// - dirty is meaningful only when the selected scheme uses the table
// - status bit 1 reports flow-control initialisation still pending
// - sixteen 4-bit writable slots, eight per word, ascending nibbles
// - slots with invalid port codes are skipped without delay
// - codes: 0 upstream, 2 to 4 downstream ports, 5 to f reserved
// - slot n resets to (n mod 7)+1
// - second word holds phases 8 to 15, phase 15 in the top nibble
// - load bit 16 acts on upstream only, clear ignored, reads zero
module vpa_arb_table (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              is_upstream,
    input  wire logic [3:0]        egress_port,
    input  wire logic              flow_init_busy,
    input  wire logic              arb_period,
    input  wire vpa_pkg::vpa_req_s req,
    output var  logic [31:0]       rdata,
    output var  vpa_pkg::vpa_grant_s grant,
    output var  logic              arb_table_dirty,
    output var  logic              flow_init_pending,
    output var  logic              table_loading
);
    logic [63:0] table_sw;
    logic [63:0] table_live;
    logic [2:0]  arb_sel;
    logic [4:0]  load_cnt;
    logic        dirty_raw;
    logic [3:0]  phase;

    // every check below lives in the core clock domain
    default clocking vpa_cb @(posedge core_clk); endclocking
    default disable iff (reset);

    wire hit_stat  = req.addr == vpa_pkg::OFF_STATUS;
    wire hit_ctl   = req.addr == vpa_pkg::OFF_CONTROL;
    wire hit_t0    = req.addr == vpa_pkg::OFF_TBL_ZERO;
    wire hit_t1    = req.addr == vpa_pkg::OFF_TBL_ONE;
    wire tbl_write = req.wr && (hit_t0 || hit_t1);
    // only a set request on the upstream port starts a copy
    wire load_req  = req.wr && hit_ctl && is_upstream
                     && req.wdata[vpa_pkg::BIT_LOAD];
    wire load_done = load_cnt == 5'h01;
    wire sel_uses  = vpa_pkg::SEL_USES_TBL[arb_sel];
    wire dirty_vis = dirty_raw && is_upstream && sel_uses;

    // per-slot validity of the live copy
    logic [15:0] slot_ok;
    genvar g;
    generate
        for (g = 0; g < vpa_pkg::NUM_PHASES; g++) begin : g_slot
            wire [3:0] code = table_live[g*4 +: 4];
            assign slot_ok[g] = (code == vpa_pkg::PORT_UP
                || (code >= vpa_pkg::PORT_FIRST_DN
                    && code <= vpa_pkg::PORT_LAST_DN))
                && code != egress_port;
        end
    endgenerate

    // next valid phase at or after the successor; invalid ones cost nothing
    logic [3:0] next_phase;
    logic       next_found;
    always_comb begin
        logic [3:0] cand;
        cand = 4'h0;
        next_phase = phase;
        next_found = 1'b0;
        for (int i = 1; i <= vpa_pkg::NUM_PHASES; i++) begin
            cand = phase + 4'(i);
            if (!next_found && slot_ok[cand]) begin
                next_phase = cand;
                next_found = 1'b1;
            end
        end
    end

    wire [31:0] stat_word = {30'h0, flow_init_busy, dirty_vis};
    wire [31:0] ctl_word  = {12'h0, arb_sel, 1'b0, 16'h0};
    wire [31:0] next_rdata = !req.rd ? 32'h0 :
        hit_stat ? stat_word :
        hit_ctl  ? ctl_word :
        hit_t0   ? table_sw[31:0] :
        hit_t1   ? table_sw[63:32] : 32'h0;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            table_sw <= vpa_pkg::TABLE_RESET;
            arb_sel  <= vpa_pkg::SEL_RESET;
        end else if (req.wr) begin
            if (hit_t0) table_sw[31:0]  <= req.wdata;
            if (hit_t1) table_sw[63:32] <= req.wdata;
            if (hit_ctl) arb_sel <= req.wdata[vpa_pkg::SEL_LSB +: 3];
        end
    end

    // a write in the load_done cycle wins: table stays dirty
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dirty_raw <= 1'b0;
            load_cnt  <= 5'h0;
            table_live <= vpa_pkg::TABLE_RESET;
        end else begin
            if (tbl_write) dirty_raw <= 1'b1;
            else if (load_done) dirty_raw <= 1'b0;
            if (load_req) load_cnt <= vpa_pkg::LOAD_CYCLES;
            else if (load_cnt != 5'h0) load_cnt <= load_cnt - 5'h01;
            if (load_done) table_live <= table_sw;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            phase <= 4'h0;
            grant <= '0;
        end else if (arb_period) begin
            phase <= next_phase;
            grant <= '{valid: next_found, port: table_live[next_phase*4 +: 4],
                       phase: next_phase};
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata             <= 32'h0;
            arb_table_dirty   <= 1'b0;
            flow_init_pending <= 1'b0;
            table_loading     <= 1'b0;
        end else begin
            rdata             <= next_rdata;
            arb_table_dirty   <= dirty_vis;
            flow_init_pending <= flow_init_busy;
            table_loading     <= load_req || (load_cnt > 5'h01);
        end
    end

    // dirty flag
    a_dirty_on_write: assert property (
        tbl_write |=> dirty_raw)
        else $error("dirty not set");

    a_dirty_holds: assert property (
        dirty_raw && !load_done |=> dirty_raw)
        else $error("dirty dropped early");

    a_dirty_clears: assert property (
        load_done && !tbl_write |=> !dirty_raw)
        else $error("dirty stuck after load");

    a_down_zero: assert property (
        !is_upstream |=> !arb_table_dirty)
        else $error("downstream dirty");

    a_sel_gates: assert property (
        !sel_uses |-> !dirty_vis)
        else $error("dirty without table");

    a_dirty_out: assert property (
        1'b1 |=> arb_table_dirty == $past(dirty_vis))
        else $error("dirty output lags");

    // status and control reads and writes
    a_pending_rd: assert property (
        req.rd && hit_stat |=> rdata[1] == $past(flow_init_busy))
        else $error("pending bit wrong");

    a_pending_out: assert property (
        1'b1 |=> flow_init_pending == $past(flow_init_busy))
        else $error("pending output lags");

    a_dirty_rd: assert property (
        req.rd && hit_stat |=> rdata[0] == $past(dirty_vis))
        else $error("dirty read wrong");

    a_stat_reserved: assert property (
        req.rd && hit_stat |=> rdata[31:2] == 30'h0)
        else $error("status reserved bits set");

    a_stat_wr_ignored: assert property (
        req.wr && hit_stat |=> table_sw == $past(table_sw)
        && arb_sel == $past(arb_sel)) else $error("status write took");

    a_load_rd_zero: assert property (
        req.rd && hit_ctl |=> !rdata[16])
        else $error("load reads one");

    a_ctl_rd_sel: assert property (
        req.rd && hit_ctl |=> rdata[19:17] == $past(arb_sel))
        else $error("selector read wrong");

    a_ctl_rd_zero: assert property (
        req.rd && hit_ctl |=> rdata[15:0] == 16'h0
        && rdata[31:20] == 12'h0) else $error("control reserved set");

    a_sel_write: assert property (
        req.wr && hit_ctl |=> arb_sel == $past(req.wdata[19:17]))
        else $error("selector write lost");

    a_unmapped_rd: assert property (
        req.rd && !(hit_stat || hit_ctl || hit_t0 || hit_t1)
        |=> rdata == 32'h0) else $error("unmapped read nonzero");

    a_rdata_idle: assert property (
        !req.rd |=> rdata == 32'h0)
        else $error("rdata outside read");

    // table storage
    a_tbl_readback: assert property (
        (req.wr && hit_t0) ##1 (req.rd && hit_t0)
        |=> rdata == $past(req.wdata, 2)) else $error("table readback");

    a_wr_t0_lands: assert property (
        req.wr && hit_t0 |=> table_sw[31:0] == $past(req.wdata))
        else $error("word zero write lost");

    a_wr_t1_lands: assert property (
        req.wr && hit_t1 |=> table_sw[63:32] == $past(req.wdata))
        else $error("word one write lost");

    a_sw_holds: assert property (
        !req.wr |=> table_sw == $past(table_sw))
        else $error("table changed unwritten");

    a_rd_t0: assert property (
        req.rd && hit_t0 |=> rdata == $past(table_sw[31:0]))
        else $error("word zero read wrong");

    a_rd_t1: assert property (
        req.rd && hit_t1 |=> rdata == $past(table_sw[63:32]))
        else $error("word one read wrong");

    // load sequence
    a_load_down: assert property (
        !is_upstream && load_cnt == 5'h0 |=> load_cnt == 5'h0)
        else $error("load on downstream");

    a_down_no_load: assert property (
        !is_upstream |-> !load_req)
        else $error("downstream load request");

    a_load_starts: assert property (
        load_req |=> load_cnt == vpa_pkg::LOAD_CYCLES)
        else $error("load count not started");

    a_load_clear_noop: assert property (
        req.wr && hit_ctl && !req.wdata[16] && load_cnt == 5'h0
        |=> load_cnt == 5'h0) else $error("clearing load acted");

    a_cnt_bound: assert property (
        1'b1 |-> load_cnt <= vpa_pkg::LOAD_CYCLES)
        else $error("load count overrun");

    a_live_copy: assert property (
        load_done |=> table_live == $past(table_sw))
        else $error("live copy wrong");

    a_live_holds: assert property (
        !load_done |=> table_live == $past(table_live))
        else $error("live table drifted");

    a_loading_on: assert property (
        load_req || load_cnt > 5'h01 |=> table_loading)
        else $error("loading flag low");

    a_loading_off: assert property (
        !load_req && load_cnt <= 5'h01 |=> !table_loading)
        else $error("loading flag stuck");

    // phase sequencer
    a_grant_valid: assert property (
        grant.valid |-> grant.port != egress_port && grant.port <= 4'h4
        && grant.port != 4'h1) else $error("bad grant");

    a_phase_hold: assert property (
        !arb_period |=> phase == $past(phase) && grant == $past(grant))
        else $error("phase moved without period");

    a_phase_step: assert property (
        arb_period |=> phase == $past(next_phase))
        else $error("phase step wrong");

    a_skip_none: assert property (
        arb_period && slot_ok[phase + 4'h1] |=> phase == $past(phase) + 4'h1)
        else $error("valid neighbour skipped");

    a_none_valid: assert property (
        arb_period && slot_ok == 16'h0 |=> !grant.valid)
        else $error("grant with empty table");

    c_write_load: cover property (
        tbl_write ##[1:20] load_done);

    c_grant: cover property (
        grant.valid);

    c_wrap: cover property (
        arb_period && next_phase < phase);

    c_down_write: cover property (
        !is_upstream && tbl_write);

    c_pending: cover property (
        flow_init_pending && req.rd && hit_stat);
endmodule : vpa_arb_table
`default_nettype wire

// ==== dv/vpa_arb_table_tb.sv ====
/* bench for the port arbitration table: strobe bus tasks, a table and
 sequencer model; assumes vpa_pkg and vpa_arb_table compiled first. */
`timescale 1ns/10ps
`default_nettype none
module vpa_arb_table_tb;
    logic                core_clk = 1'b0;
    logic                reset = 1'b1;
    logic                is_up = 1'b1;
    logic                busy = 1'b0;
    logic                period = 1'b0;
    vpa_pkg::vpa_req_s   req = '0;
    logic [31:0]         rdata;
    vpa_pkg::vpa_grant_s grant;
    logic                dirty, pend, loading;
    // sequencer sits on phase 0 after reset, so the first search starts at 1
    int                  mismatches = 0, check_count = 0, cyc = 0, ptr = 1;
    // legal codes 0, 2, 4 plus invalid 1, an absent port to skip; egress 3 and reserved left out
    logic [3:0]          codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h1, 4'h2};
    logic [31:0]         seed = 32'h2225;
    logic [3:0]          tbl [16];
    logic [3:0]          act [16];
    always #2.5 core_clk = ~core_clk;
    // egress tied to port 3 so its own slots must be skipped
    vpa_arb_table DUT (.core_clk(core_clk), .reset(reset),
        .is_upstream(is_up), .egress_port(4'h3), .flow_init_busy(busy),
        .arb_period(period), .req(req), .rdata(rdata), .grant(grant),
        .arb_table_dirty(dirty), .flow_init_pending(pend),
        .table_loading(loading));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [31:0] word(int w);
        logic [31:0] d;
        for (int i = 0; i < 8; i++) d[4*i+:4] = tbl[8*w+i];
        return d;
    endfunction : word
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(string n, logic [11:0] a, logic [31:0] e);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask : rd
    task automatic wtbl();
        wr(vpa_pkg::OFF_TBL_ZERO, word(0));
        wr(vpa_pkg::OFF_TBL_ONE, word(1));
    endtask : wtbl
    task automatic step();
        int k;
        @(posedge core_clk);
        period <= 1'b1;
        @(posedge core_clk);
        period <= 1'b0;
        for (k = 0; k < 16; k++) begin
            if (act[(ptr+k)%16] inside {4'h0, 4'h2, 4'h4}) break;
        end
        ptr = (ptr + k) % 16;
        #1 chk("grant", {23'h0, 1'b1, act[ptr], 4'(ptr)}, 32'(grant));
        ptr = (ptr + 1) % 16;
    endtask : step
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // a hang costs a mismatch, never a silent pass
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 16; i++) tbl[i] = 4'(i % 7 + 1);
        rd("tbl0", vpa_pkg::OFF_TBL_ZERO, word(0));
        rd("tbl1", vpa_pkg::OFF_TBL_ONE, word(1));
        rd("status", vpa_pkg::OFF_STATUS, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) tbl[i] = 4'(xs());
        wtbl();
        rd("status", vpa_pkg::OFF_STATUS, 32'h0);
        wr(vpa_pkg::OFF_CONTROL, 32'h0002_0000);
        rd("ctl", vpa_pkg::OFF_CONTROL, 32'h0002_0000);
        rd("status", vpa_pkg::OFF_STATUS, 32'h1);
        chk("dirty", 32'h1, 32'(dirty));
        rd("tbl0", vpa_pkg::OFF_TBL_ZERO, word(0));
        rd("tbl1", vpa_pkg::OFF_TBL_ONE, word(1));
        wr(vpa_pkg::OFF_CONTROL, 32'h0003_0000);
        rd("status", vpa_pkg::OFF_STATUS, 32'h1);
        chk("loading", 32'h1, 32'(loading));
        repeat (20) @(posedge core_clk);
        rd("status", vpa_pkg::OFF_STATUS, 32'h0);
        chk("dirty", 32'h0, 32'(dirty));
        $display("test dirty done");
        @(posedge core_clk) is_up <= 1'b0;
        wtbl();
        wr(vpa_pkg::OFF_CONTROL, 32'h0003_0000);
        #1 chk("loading", 32'h0, 32'(loading));
        rd("status", vpa_pkg::OFF_STATUS, 32'h0);
        @(posedge core_clk) busy <= 1'b1;
        rd("status", vpa_pkg::OFF_STATUS, 32'h2);
        chk("pending", 32'h1, 32'(pend));
        @(posedge core_clk) busy <= 1'b0;
        rd("status", vpa_pkg::OFF_STATUS, 32'h0);
        wr(vpa_pkg::OFF_STATUS, 32'hffff_ffff);
        rd("status", vpa_pkg::OFF_STATUS, 32'h0);
        rd("unmapped", 12'h300, 32'h0);
        $display("test downstream done");
        @(posedge core_clk) is_up <= 1'b1;
        for (int i = 0; i < 16; i++) tbl[i] = codes[xs() % 6];
        tbl[15] = 4'h0; // keeps one slot grantable
        wtbl();
        wr(vpa_pkg::OFF_CONTROL, 32'h0003_0000);
        act = tbl;
        repeat (20) @(posedge core_clk);
        for (int i = 0; i < 24; i++) step();
        $display("test grant done");
        results();
    end
endmodule : vpa_arb_table_tb
`default_nettype wire
